// ==== rtl/modem_dial_sequencer.sv ====
// Modem originate and hang-up command sequencer with register port
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// RULE1: Simultaneous starts refused, status code 61
// RULE2: Each start runs its sequence once
// RULE3: Failed command reissued up to retry count
// RULE4: Full: setup, reset, dial; reset: reset, dial
// RULE5: Default setup string loaded on run start
// RULE6: Setup string sent with AT and LF
// RULE7: Earlier character in upper byte of word
// RULE8: Program ends each string with CR
// RULE9: Setup result flag, later step flags too
// RULE10: One setup store for every mode
// RULE11: Reset result flag, dial flag if dialed
// RULE12: Number store thirty words, sixty characters
// RULE13: Dial sent as ATD, number, LF
// RULE14: Dial retried at retry interval spacing
// RULE15: Dial succeeds only when carrier detected
// RULE16: Port protocol follows connection and selector
// RULE17: Port returns to command state after drop
// RULE18: Stopped controller forces maintenance protocol
// RULE19: Hang-up start drops terminal ready
// RULE20: Hang-up succeeds when carrier drops
// RULE21: No new command while one runs
// RULE22: Program waits a second after connecting
// RULE23: Retry count zero means no retry
// RULE24: Any start clears all result flags
// RULE25: Connected flag follows line state
// RULE26: Final failure reports execution error code
// RULE27: Start taken on rising flag edge
module modem_dial_sequencer #(
	parameter int CYC_PER_SEC    = modem_pkg::CYC_PER_SEC,
	parameter int RESP_TIMEOUT_S = modem_pkg::RESP_TIMEOUT_S,
	parameter int HANG_TIMEOUT_S = modem_pkg::HANG_TIMEOUT_S
) (
	input  wire logic                   CLK,
	input  wire logic                   RST,
	input  wire logic [6:0]             ADDR,
	input  wire logic [15:0]            WDATA,
	input  wire logic                   WR,
	input  wire logic                   RD,
	output var  logic [15:0]            RDATA,
	input  wire logic                   MODEM_EN,
	input  wire logic                   RUN,
	input  wire logic                   RESP_OK,
	input  wire logic                   RESP_ERR,
	input  wire logic                   DCD,
	output var  logic                   DTR,
	output var  logic [7:0]             TX_DATA,
	output var  logic                   TX_VALID,
	input  wire logic                   TX_READY,
	output var  modem_pkg::port_mode_t  PORT_MODE,
	output var  logic                   LINE_UP
);
	if (CYC_PER_SEC < 2 || RESP_TIMEOUT_S < 1 || HANG_TIMEOUT_S < 1 ||
			RESP_TIMEOUT_S > 65535 || HANG_TIMEOUT_S > 65535) begin : g_chk
		$error("modem_dial_sequencer: unusable timing parameters");
	end

	// Map a register port address onto the character store
	function automatic logic [6:0] store_idx(input logic [6:0] a);
		logic [6:0] r;
		r = 7'h7f;
		if (a >= modem_pkg::INIT_ADDR && a < modem_pkg::INIT_ADDR + 7'd25) begin
			r = a - modem_pkg::INIT_ADDR;
		end else if (a >= modem_pkg::PHONE_ADDR && a < modem_pkg::PHONE_ADDR + 7'd30) begin
			r = a - modem_pkg::PHONE_ADDR + 7'd25;
		end
		return r;
	endfunction : store_idx

	// Character at a point of a command: prefix, body, closing LF
	function automatic logic [7:0] char_at(input modem_pkg::step_t s, input logic [1:0] ph,
			input logic [5:0] pos, input logic [15:0] w);
		logic [7:0] c;
		c = modem_pkg::CH_LF;
		if (ph == 2'h0) begin
			c = (pos == 6'h0) ? modem_pkg::CH_A : (pos == 6'h1) ? modem_pkg::CH_T : modem_pkg::CH_D;
		end else if (ph == 2'h1) begin
			if (s == modem_pkg::STEP_RESET) begin
				c = (pos == 6'h0) ? modem_pkg::CH_Z : modem_pkg::CH_CR;
			end else begin
				c = pos[0] ? w[7:0] : w[15:8];
			end
		end
		return c;
	endfunction : char_at

	logic [15:0]          store [0:modem_pkg::STORE_WORDS-1];
	logic [3:0]           ctrl_reg;
	logic [3:0]           ctrl_prev_reg;
	logic [15:0]          sel_reg;
	logic [15:0]          rcnt_reg;
	logic [15:0]          rint_reg;
	logic [15:0]          status_reg;
	modem_pkg::result_t   result_reg;
	modem_pkg::state_t    state_reg;
	modem_pkg::step_t     step_reg;
	modem_pkg::step_t     last_reg;
	logic [1:0]           phase_reg;
	logic [5:0]           pos_reg;
	logic [15:0]          attempt_reg;
	logic                 line_reg;
	logic                 run_prev_reg;
	logic                 dcd_meta_reg;
	logic                 dcd_reg;
	logic [31:0]          pre_reg;
	logic [15:0]          sec_reg;
	logic [3:0]           rise;
	logic [2:0]           nrise;
	logic [5:0]           widx;
	logic [7:0]           cur_char;
	logic                 tmr_clr;
	logic                 ok_ev;
	logic                 fail_ev;
	logic [6:0]           bus_idx;

	////////////////////////////////////////////////////////////////////////////////
	// Carrier detect pin into the clock domain
	always_ff @(posedge CLK) begin
		if (RST) begin
			dcd_meta_reg <= 1'b0;
			dcd_reg      <= 1'b0;
		end else begin
			dcd_meta_reg <= DCD;
			dcd_reg      <= dcd_meta_reg;
		end
	end

	// Seconds timer, restarted whenever no wait is running
	assign tmr_clr = !(state_reg inside {modem_pkg::S_RESP, modem_pkg::S_DIALWAIT,
		modem_pkg::S_HANG});
	always_ff @(posedge CLK) begin
		if (RST || tmr_clr) begin
			pre_reg <= 32'h0;
			sec_reg <= 16'h0;
		end else if (pre_reg == 32'(CYC_PER_SEC - 1)) begin
			pre_reg <= 32'h0;
			if (sec_reg != 16'hffff) begin
				sec_reg <= sec_reg + 16'h1;
			end
		end else begin
			pre_reg <= pre_reg + 32'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes and start flags; retry count and interval defaults on each run start
	assign bus_idx = store_idx(ADDR);
	always_ff @(posedge CLK) begin
		if (RST) begin
			ctrl_reg     <= 4'h0;
			sel_reg      <= 16'h0;
			rcnt_reg     <= modem_pkg::RCNT_RST;
			rint_reg     <= modem_pkg::RINT_RST;
			run_prev_reg <= 1'b0;
		end else begin
			run_prev_reg <= RUN;
			if (RUN && !run_prev_reg) begin
				rcnt_reg <= modem_pkg::RCNT_RST;
				rint_reg <= modem_pkg::RINT_RST;
			end
			if (WR && ADDR == modem_pkg::CTRL_ADDR) begin
				ctrl_reg <= WDATA[3:0];
			end
			if (WR && ADDR == modem_pkg::SEL_ADDR) begin
				sel_reg <= WDATA;
			end
			if (WR && ADDR == modem_pkg::RCNT_ADDR) begin
				rcnt_reg <= WDATA;
			end
			if (WR && ADDR == modem_pkg::RINT_ADDR) begin
				rint_reg <= WDATA;
			end
		end
	end

	// Character stores, two characters a word
	always_ff @(posedge CLK) begin
		if (RST) begin
			for (int i = 0; i < modem_pkg::STORE_WORDS; i++) begin
				store[i] <= 16'h0;
			end
		end else if (MODEM_EN && RUN && !run_prev_reg) begin
			for (int i = 0; i < modem_pkg::INIT_WORDS; i++) begin
				store[i] <= modem_pkg::DEF_INIT[16*(24-i) +: 16];  // [RULE5] [RULE7]
			end
		end else if (WR && bus_idx != 7'h7f) begin
			store[bus_idx[5:0]] <= WDATA;
		end
	end

	// Read data, one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge CLK) begin
		if (RST) begin
			RDATA <= 16'h0;
		end else if (RD) begin
			case (ADDR)
				modem_pkg::CTRL_ADDR:  RDATA <= {12'h0, ctrl_reg};
				modem_pkg::FLAGS_ADDR: RDATA <= {6'h0, state_reg != modem_pkg::S_IDLE,
					line_reg, result_reg};
				modem_pkg::SEL_ADDR:   RDATA <= sel_reg;
				modem_pkg::RCNT_ADDR:  RDATA <= rcnt_reg;
				modem_pkg::RINT_ADDR:  RDATA <= rint_reg;
				modem_pkg::STAT_ADDR:  RDATA <= MODEM_EN ? status_reg : modem_pkg::ST_OFF;
				default:               RDATA <= (bus_idx != 7'h7f) ? store[bus_idx[5:0]] : 16'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Start edges, outgoing character and end of each wait
	assign rise  = ctrl_reg & ~ctrl_prev_reg;  // [RULE27]
	assign nrise = 3'(rise[0]) + 3'(rise[1]) + 3'(rise[2]) + 3'(rise[3]);
	assign widx  = ((step_reg == modem_pkg::STEP_DIAL) ? modem_pkg::PHONE_BASE :
		modem_pkg::INIT_BASE) + {1'b0, pos_reg[5:1]};  // [RULE10]
	assign cur_char = char_at(step_reg, phase_reg, pos_reg, store[widx]);  // [RULE6] [RULE13]
	assign ok_ev = (state_reg == modem_pkg::S_RESP && RESP_OK) ||
		(state_reg == modem_pkg::S_DIALWAIT && dcd_reg) ||  // [RULE15]
		(state_reg == modem_pkg::S_HANG && !dcd_reg);  // [RULE20]
	assign fail_ev = !ok_ev && (
		(state_reg == modem_pkg::S_RESP && (RESP_ERR || sec_reg >= 16'(RESP_TIMEOUT_S))) ||
		(state_reg == modem_pkg::S_DIALWAIT &&
			sec_reg >= ((rint_reg == 16'h0) ? 16'h1 : rint_reg)) ||  // [RULE14]
		(state_reg == modem_pkg::S_HANG && sec_reg >= 16'(HANG_TIMEOUT_S)));

	// Command sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state_reg     <= modem_pkg::S_IDLE;
			step_reg      <= modem_pkg::STEP_INIT;
			last_reg      <= modem_pkg::STEP_DIAL;
			phase_reg     <= 2'h0;
			pos_reg       <= 6'h0;
			attempt_reg   <= 16'h0;
			ctrl_prev_reg <= 4'h0;
			result_reg    <= '0;
			status_reg    <= modem_pkg::ST_READY;
			line_reg      <= 1'b0;
			DTR           <= 1'b1;
			TX_DATA       <= 8'h0;
			TX_VALID      <= 1'b0;
		end else begin
			ctrl_prev_reg <= ctrl_reg;
			case (state_reg)
				modem_pkg::S_IDLE: begin
					if (MODEM_EN && rise != 4'h0) begin  // [RULE21]
						result_reg  <= '0;  // [RULE24]
						attempt_reg <= 16'h0;
						phase_reg   <= 2'h0;
						pos_reg     <= 6'h0;
						if (nrise > 3'h1) begin
							status_reg <= modem_pkg::ST_MULTI;  // [RULE1]
						end else if (line_reg && !rise[3]) begin
							status_reg <= modem_pkg::ST_ONLINE_BAD;
						end else if (rise[3]) begin
							step_reg   <= modem_pkg::STEP_HANG;
							last_reg   <= modem_pkg::STEP_HANG;
							DTR        <= 1'b0;  // [RULE19]
							state_reg  <= modem_pkg::S_HANG;
							status_reg <= modem_pkg::ST_RUN0 + 16'h3;
						end else begin
							// Sequence begins at the first step of the chosen start
							step_reg   <= rise[0] ? modem_pkg::STEP_INIT :
								rise[1] ? modem_pkg::STEP_RESET : modem_pkg::STEP_DIAL;  // [RULE4]
							last_reg   <= modem_pkg::STEP_DIAL;
							state_reg  <= modem_pkg::S_LOAD;  // [RULE2]
							status_reg <= modem_pkg::ST_RUN0 + {14'h0, rise[2], rise[1]};
						end
					end else if (line_reg && !dcd_reg) begin
						line_reg   <= 1'b0;  // [RULE25]
						status_reg <= modem_pkg::ST_READY;
					end
				end
				modem_pkg::S_LOAD: begin
					TX_DATA   <= cur_char;
					TX_VALID  <= 1'b1;
					state_reg <= modem_pkg::S_SEND;
				end
				modem_pkg::S_SEND: begin
					if (TX_READY) begin
						TX_VALID  <= 1'b0;
						state_reg <= modem_pkg::S_LOAD;
						pos_reg   <= pos_reg + 6'h1;
						if (phase_reg == 2'h0) begin
							if (pos_reg == ((step_reg == modem_pkg::STEP_DIAL) ? 6'h2 : 6'h1)) begin
								phase_reg <= 2'h1;
								pos_reg   <= 6'h0;
							end
						end else if (phase_reg == 2'h1) begin
							// Body ends at CR or at the end of its store
							if (TX_DATA == modem_pkg::CH_CR || pos_reg == ((step_reg ==
									modem_pkg::STEP_DIAL) ? modem_pkg::PHONE_LAST :
									modem_pkg::INIT_LAST)) begin  // [RULE8] [RULE12]
								phase_reg <= 2'h2;
							end
						end else begin
							state_reg <= (step_reg == modem_pkg::STEP_DIAL) ?
								modem_pkg::S_DIALWAIT : modem_pkg::S_RESP;
						end
					end
				end
				modem_pkg::S_GAP: begin
					phase_reg  <= 2'h0;
					pos_reg    <= 6'h0;
					status_reg <= modem_pkg::ST_RUN0 + {14'h0, step_reg};
					state_reg  <= (step_reg == modem_pkg::STEP_HANG) ? modem_pkg::S_HANG :
						modem_pkg::S_LOAD;
				end
				default: begin
					// Waiting for the modem's answer, carrier, or carrier loss
					if (ok_ev) begin
						result_reg.done[step_reg] <= 1'b1;  // [RULE9] [RULE11]
						if (step_reg == last_reg) begin
							state_reg <= modem_pkg::S_IDLE;
							if (step_reg == modem_pkg::STEP_DIAL) begin
								line_reg   <= 1'b1;  // [RULE25]
								status_reg <= modem_pkg::ST_ONLINE;
							end else begin
								line_reg   <= 1'b0;  // [RULE17]
								DTR        <= 1'b1;
								status_reg <= modem_pkg::ST_READY;
							end
						end else begin
							step_reg    <= modem_pkg::step_t'(step_reg + 2'h1);  // [RULE4]
							attempt_reg <= 16'h0;
							phase_reg   <= 2'h0;
							pos_reg     <= 6'h0;
							state_reg   <= modem_pkg::S_LOAD;
							status_reg  <= modem_pkg::ST_RUN0 + {14'h0, step_reg} + 16'h1;
						end
					end else if (fail_ev) begin
						if (attempt_reg < rcnt_reg) begin  // [RULE3] [RULE23]
							attempt_reg <= attempt_reg + 16'h1;
							state_reg   <= modem_pkg::S_GAP;
							status_reg  <= modem_pkg::ST_WAIT0 + {14'h0, step_reg};
						end else begin
							result_reg.fail[step_reg] <= 1'b1;
							status_reg <= modem_pkg::ST_EXEC_ERR;  // [RULE26]
							state_reg  <= modem_pkg::S_IDLE;
							DTR        <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Port protocol after connection
	always_ff @(posedge CLK) begin
		if (RST) begin
			PORT_MODE <= modem_pkg::PM_AT;
		end else if (!line_reg) begin
			PORT_MODE <= modem_pkg::PM_AT;  // [RULE16] [RULE17]
		end else if (!RUN || sel_reg != 16'h1) begin
			PORT_MODE <= modem_pkg::PM_MAINT;  // [RULE18]
		end else begin
			PORT_MODE <= modem_pkg::PM_USER;
		end
	end

	assign LINE_UP = line_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	property p_multi;
		state_reg == modem_pkg::S_IDLE && MODEM_EN && nrise > 3'h1 |=>
			status_reg == modem_pkg::ST_MULTI && state_reg == modem_pkg::S_IDLE;
	endproperty
	a_multi: assert property (p_multi) else $error("simultaneous starts not refused"); // [RULE1]

	property p_clear;
		state_reg == modem_pkg::S_IDLE && MODEM_EN && rise != 4'h0 |=> result_reg == '0;
	endproperty
	a_clear: assert property (p_clear) else $error("start left result flags"); // [RULE24]

	property p_busy;
		state_reg != modem_pkg::S_IDLE && state_reg != modem_pkg::S_GAP && !ok_ev |=>
			$stable(step_reg);
	endproperty
	a_busy: assert property (p_busy) else $error("command changed mid run"); // [RULE21]

	property p_dial;
		state_reg == modem_pkg::S_DIALWAIT && dcd_reg |=> line_reg && result_reg.done[2]
			##1 PORT_MODE != modem_pkg::PM_AT;
	endproperty
	a_dial: assert property (p_dial) else $error("carrier did not connect line"); // [RULE15]

	property p_hang;
		state_reg == modem_pkg::S_HANG |-> !DTR;
	endproperty
	a_hang: assert property (p_hang) else $error("terminal ready high in hang-up"); // [RULE19]

	property p_hang_done;
		state_reg == modem_pkg::S_HANG && !dcd_reg |=> result_reg.done[3] && !line_reg && DTR;
	endproperty
	a_hang_done: assert property (p_hang_done) else $error("hang-up not completed"); // [RULE20]

	property p_stop;
		line_reg && !RUN |=> PORT_MODE == modem_pkg::PM_MAINT;
	endproperty
	a_stop: assert property (p_stop) else $error("stopped port not maintenance"); // [RULE18]

	property p_drop;
		!line_reg ##1 !line_reg |-> PORT_MODE == modem_pkg::PM_AT;
	endproperty
	a_drop: assert property (p_drop) else $error("port not back to command state"); // [RULE17]

	property p_final;
		fail_ev && attempt_reg >= rcnt_reg |=> status_reg == modem_pkg::ST_EXEC_ERR &&
			result_reg.fail[step_reg] && state_reg == modem_pkg::S_IDLE;
	endproperty
	a_final: assert property (p_final) else $error("final failure not reported"); // [RULE26]

	property p_lf;
		state_reg == modem_pkg::S_SEND && TX_READY && phase_reg == 2'h2 |-> TX_DATA == 8'h0a;
	endproperty
	a_lf: assert property (p_lf) else $error("command not closed by LF"); // [RULE6]

	c_dial_ok: cover property (state_reg == modem_pkg::S_DIALWAIT && dcd_reg);
	c_retry:   cover property (state_reg == modem_pkg::S_GAP);
	c_hang_ok: cover property (state_reg == modem_pkg::S_HANG && !dcd_reg);
endmodule : modem_dial_sequencer

`default_nettype wire

// ==== rtl/modem_pkg.sv ====
// Constants, register map and types of the modem dial sequencer
package modem_pkg;
	// Clock and time base
	localparam int SEC_NS        = 1_000_000_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
	localparam int RESP_TIMEOUT_S = 5;   // Wait for modem answer to a command
	localparam int HANG_TIMEOUT_S = 5;   // Wait for carrier to drop after hang-up

	// Register map, word addresses on the register port
	localparam int           ADDR_W      = 7;
	localparam logic [6:0]   CTRL_ADDR   = 7'h00;
	localparam logic [6:0]   FLAGS_ADDR  = 7'h01;
	localparam logic [6:0]   SEL_ADDR    = 7'h02;
	localparam logic [6:0]   RCNT_ADDR   = 7'h03;
	localparam logic [6:0]   RINT_ADDR   = 7'h04;
	localparam logic [6:0]   STAT_ADDR   = 7'h05;
	localparam logic [6:0]   INIT_ADDR   = 7'h20;
	localparam logic [6:0]   PHONE_ADDR  = 7'h40;

	// Character store layout
	localparam int           INIT_WORDS  = 25;
	localparam int           PHONE_WORDS = 30;
	localparam int           STORE_WORDS = INIT_WORDS + PHONE_WORDS;
	localparam logic [5:0]   INIT_BASE   = 6'h00;
	localparam logic [5:0]   PHONE_BASE  = 6'h19;
	localparam logic [5:0]   INIT_LAST   = 6'h31;  // 50 characters
	localparam logic [5:0]   PHONE_LAST  = 6'h3b;  // 60 characters

	// Reset values
	localparam logic [15:0]  RCNT_RST    = 16'h0003;
	localparam logic [15:0]  RINT_RST    = 16'h005a;

	// Status codes
	localparam logic [15:0]  ST_OFF      = 16'h0000;
	localparam logic [15:0]  ST_READY    = 16'h000a;
	localparam logic [15:0]  ST_RUN0     = 16'h0014;
	localparam logic [15:0]  ST_WAIT0    = 16'h001e;
	localparam logic [15:0]  ST_ONLINE   = 16'h0028;
	localparam logic [15:0]  ST_MULTI    = 16'h003d;
	localparam logic [15:0]  ST_ONLINE_BAD = 16'h003e;
	localparam logic [15:0]  ST_EXEC_ERR = 16'h003f;

	// Characters
	localparam logic [7:0]   CH_A  = 8'h41;
	localparam logic [7:0]   CH_T  = 8'h54;
	localparam logic [7:0]   CH_D  = 8'h44;
	localparam logic [7:0]   CH_Z  = 8'h5a;
	localparam logic [7:0]   CH_CR = 8'h0d;
	localparam logic [7:0]   CH_LF = 8'h0a;

	// Default setup string, two characters to a word, earlier one high
	localparam logic [16*INIT_WORDS-1:0] DEF_INIT =
		{"E0Q0V1&D2&C1\\V0X4&K3\\A0\\N5S0=2&W", 8'h0d, 8'h00, 128'h0};

	typedef enum logic [1:0] {STEP_INIT, STEP_RESET, STEP_DIAL, STEP_HANG} step_t;
	typedef enum logic [2:0] {S_IDLE, S_LOAD, S_SEND, S_RESP, S_DIALWAIT, S_HANG,
		S_GAP} state_t;
	typedef enum logic [1:0] {PM_AT, PM_MAINT, PM_USER} port_mode_t;
	typedef struct packed {
		logic [3:0] fail;
		logic [3:0] done;
	} result_t;
endpackage : modem_pkg

// ==== test/modem_model.sv ====
// Behavioural telephone modem at the far end of the serial port
`timescale 1ns/1ps
`default_nettype none

module modem_model (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic [7:0] TX_DATA,
	input  wire logic       TX_VALID,
	input  wire logic       DTR,
	input  wire logic       refuse,
	input  wire logic       dial_ok,
	input  wire logic       slow,
	output var  logic       TX_READY,
	output var  logic       RESP_OK,
	output var  logic       RESP_ERR,
	output var  logic       DCD
);
	logic [63:0] cur;
	logic [63:0] last_line;
	logic [23:0] head;
	logic        err_l;
	logic        dial_l;
	int          cur_len;
	int          n_lines;
	int          resp_cnt;
	int          cyc;
	int          len_hist [16];
	int          t_hist [16];

	////////////////////////////////////////////////////////////////////////////
	// Quiet outputs before the first clock edge
	initial begin
		TX_READY = 1'b0;
		RESP_OK = 1'b0;
		RESP_ERR = 1'b0;
		DCD = 1'b0;
		cyc = 0;
	end

	// Gather characters into lines, answer a few cycles after each LF, except a dial line while dial_ok is low
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		RESP_OK <= 1'b0;
		RESP_ERR <= 1'b0;
		TX_READY <= slow ? ~TX_READY : 1'b1;  // Stalls every other cycle when slow
		if (resp_cnt > 0) resp_cnt <= resp_cnt - 1;
		if (RST) begin
			cur <= '0;
			cur_len <= 0;
			n_lines <= 0;
			resp_cnt <= 0;
			head <= '0;
			DCD <= 1'b0;
		end else if (TX_VALID && TX_READY) begin
			if (TX_DATA == 8'h0a) begin
				last_line <= {cur[55:0], TX_DATA};
				len_hist[n_lines % 16] <= cur_len + 1;
				t_hist[n_lines % 16] <= cyc;
				n_lines <= n_lines + 1;
				cur <= '0;
				cur_len <= 0;
				head <= '0;
				resp_cnt <= 3;
				err_l <= refuse;  // Answer kind fixed when the line ends
				dial_l <= (head == 24'h415444);
			end else begin
				cur <= {cur[55:0], TX_DATA};
				cur_len <= cur_len + 1;
				if (cur_len < 3) head <= {head[15:0], TX_DATA};
			end
		end
		if (!RST && resp_cnt == 1) begin
			if (dial_l) begin
				if (dial_ok) DCD <= 1'b1;  // Carrier once the call connects
			end else if (err_l) RESP_ERR <= 1'b1;
			else RESP_OK <= 1'b1;
		end
		if (!DTR) DCD <= 1'b0;  // Terminal ready low hangs up the call
	end
endmodule : modem_model

`default_nettype wire

// ==== test/modem_dial_sequencer_tb_top.sv ====
// Self-checking testbench of the modem dial sequencer
`timescale 1ns/1ps
`default_nettype none

module modem_dial_sequencer_tb_top;
	localparam int CPS = 10;
	logic                 CLK = 1'b0;
	logic                 RST = 1'b1;
	logic                 WR = 1'b0;
	logic                 RD = 1'b0;
	logic                 MODEM_EN = 1'b1;
	logic                 RUN = 1'b0;
	logic [6:0]           ADDR = 7'h00;
	logic [15:0]          WDATA = 16'h0000;
	logic [15:0]          RDATA;
	logic                 RESP_OK, RESP_ERR, DCD, DTR, TX_VALID, TX_READY, LINE_UP;
	logic [7:0]           TX_DATA;
	modem_pkg::port_mode_t PORT_MODE;
	logic                 refuse = 1'b0;
	logic                 dial_ok = 1'b1;
	logic                 slow = 1'b0;
	int                   fails = 0;
	int                   n_checks = 0;
	int                   n0;
	int                   dt;

	always #20 CLK = ~CLK;

	modem_dial_sequencer #(.CYC_PER_SEC(CPS)) i_dut (.CLK(CLK), .RST(RST), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MODEM_EN(MODEM_EN), .RUN(RUN),
		.RESP_OK(RESP_OK), .RESP_ERR(RESP_ERR), .DCD(DCD), .DTR(DTR), .TX_DATA(TX_DATA),
		.TX_VALID(TX_VALID), .TX_READY(TX_READY), .PORT_MODE(PORT_MODE), .LINE_UP(LINE_UP));
	modem_model i_modem (.CLK(CLK), .RST(RST), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID),
		.DTR(DTR), .refuse(refuse), .dial_ok(dial_ok), .slow(slow), .TX_READY(TX_READY),
		.RESP_OK(RESP_OK), .RESP_ERR(RESP_ERR), .DCD(DCD));

	////////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : wrap_up

	// Compare one value
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	// Register port write and read
	task automatic wr(input logic [6:0] a, input logic [15:0] v);
		@(posedge CLK);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= v;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	task automatic rd(input logic [6:0] a, output logic [15:0] q);
		@(posedge CLK);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		#1 q = RDATA;  // Read data stand from the cycle after the strobe until the next read
	endtask : rd

	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		rd(a, q);
		chk(q, exp);
	endtask : rdc

	// Clear the start bits, then raise the requested ones
	task automatic go(input logic [15:0] v);
		wr(modem_pkg::CTRL_ADDR, 16'h0000);
		wr(modem_pkg::CTRL_ADDR, v);
		repeat (3) @(posedge CLK);
	endtask : go

	// Poll busy until low, bounded
	task automatic wait_idle;
		int i;
		logic [15:0] q;
		for (i = 0; i < 3000; i++) begin
			rd(modem_pkg::FLAGS_ADDR, q);
			if (q[9] === 1'b0) break;
		end
		if (i == 3000) begin
			fails++;
			wrap_up();
		end
	endtask : wait_idle

	// Hang up and expect the line down
	task automatic hang;
		go(16'h0008);
		chk(DTR, 1'b0);
		wait_idle();
		rdc(modem_pkg::FLAGS_ADDR, 16'h0008);
		chk(PORT_MODE, modem_pkg::PM_AT);
	endtask : hang

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (12) @(posedge CLK);
		RST <= 1'b0;
		rdc(modem_pkg::RCNT_ADDR, modem_pkg::RCNT_RST);
		rdc(modem_pkg::RINT_ADDR, modem_pkg::RINT_RST);
		rdc(modem_pkg::INIT_ADDR, 16'h0000);
		@(posedge CLK);
		RUN <= 1'b1;
		repeat (3) @(posedge CLK);
		rdc(modem_pkg::INIT_ADDR, 16'h4530);
		rdc(modem_pkg::INIT_ADDR + 7'd16, 16'h0d00);
		// Number store: digits, CR, and its far ends
		wr(modem_pkg::PHONE_ADDR, 16'h3132);
		wr(modem_pkg::PHONE_ADDR + 7'd1, 16'h3334);
		wr(modem_pkg::PHONE_ADDR + 7'd2, 16'h0d00);
		wr(modem_pkg::PHONE_ADDR + 7'd29, 16'h5a5a);
		rdc(modem_pkg::PHONE_ADDR + 7'd29, 16'h5a5a);
		wr(7'h5e, 16'hffff);
		rdc(7'h5e, 16'h0000);
		// Dial only, line comes up
		wr(modem_pkg::RCNT_ADDR, 16'h0000);
		n0 = i_modem.n_lines;
		go(16'h0004);
		wait_idle();
		chk(i_modem.n_lines - n0, 1);
		chk(i_modem.last_line, 64'h5444313233340d0a);
		chk(i_modem.len_hist[n0 % 16], 9);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0104);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_ONLINE);
		chk(PORT_MODE, modem_pkg::PM_MAINT);
		repeat (CPS) @(posedge CLK);
		wr(modem_pkg::SEL_ADDR, 16'h0001);
		repeat (2) @(posedge CLK);
		chk(PORT_MODE, modem_pkg::PM_USER);
		RUN <= 1'b0;
		repeat (3) @(posedge CLK);
		chk(PORT_MODE, modem_pkg::PM_MAINT);
		chk(LINE_UP, 1'b1);
		RUN <= 1'b1;
		repeat (3) @(posedge CLK);
		chk(PORT_MODE, modem_pkg::PM_USER);
		// Dial start while online is refused and clears the flags
		go(16'h0004);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_ONLINE_BAD);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0100);
		hang();
		// Full originate through a stalling transmitter
		wr(modem_pkg::RCNT_ADDR, 16'h0000);
		slow <= 1'b1;
		n0 = i_modem.n_lines;
		go(16'h0001);
		wait_idle();
		slow <= 1'b0;
		chk(i_modem.n_lines - n0, 3);
		chk(i_modem.len_hist[n0 % 16], 36);
		chk(i_modem.len_hist[(n0 + 1) % 16], 5);
		chk(i_modem.len_hist[(n0 + 2) % 16], 9);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0107);
		hang();
		// Reset originate: first reset answered with error, one retry
		wr(modem_pkg::RCNT_ADDR, 16'h0001);
		refuse <= 1'b1;
		n0 = i_modem.n_lines;
		go(16'h0002);
		for (int i = 0; i < 500 && i_modem.n_lines == n0; i++) @(posedge CLK);
		if (i_modem.n_lines == n0) begin
			fails++;
			wrap_up();
		end
		refuse <= 1'b0;
		wait_idle();
		chk(i_modem.n_lines - n0, 3);
		chk(i_modem.len_hist[(n0 + 1) % 16], 5);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0106);
		hang();
		// Reset refused with no retry: sequence stops with final error
		wr(modem_pkg::RCNT_ADDR, 16'h0000);
		refuse <= 1'b1;
		n0 = i_modem.n_lines;
		go(16'h0002);
		wait_idle();
		refuse <= 1'b0;
		chk(i_modem.n_lines - n0, 1);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0020);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_EXEC_ERR);
		// No carrier: one redial one second after the first
		wr(modem_pkg::RCNT_ADDR, 16'h0001);
		wr(modem_pkg::RINT_ADDR, 16'h0001);
		dial_ok <= 1'b0;
		n0 = i_modem.n_lines;
		go(16'h0004);
		wait_idle();
		dial_ok <= 1'b1;
		chk(i_modem.n_lines - n0, 2);
		dt = i_modem.t_hist[(n0 + 1) % 16] - i_modem.t_hist[n0 % 16];
		chk(dt >= CPS + 18 && dt < CPS + 40, 1);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0040);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_EXEC_ERR);
		// Two starts at once, then the same bits written again
		n0 = i_modem.n_lines;
		go(16'h0003);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_MULTI);
		rdc(modem_pkg::FLAGS_ADDR, 16'h0000);
		wr(modem_pkg::CTRL_ADDR, 16'h0003);
		repeat (20) @(posedge CLK);
		chk(i_modem.n_lines - n0, 0);
		// Modem mode off: status reads zero and a run start keeps the store
		MODEM_EN <= 1'b0;
		wr(modem_pkg::INIT_ADDR, 16'h4142);
		rdc(modem_pkg::STAT_ADDR, modem_pkg::ST_OFF);
		RUN <= 1'b0;
		repeat (2) @(posedge CLK);
		RUN <= 1'b1;
		repeat (3) @(posedge CLK);
		rdc(modem_pkg::INIT_ADDR, 16'h4142);
		wrap_up();
	end
endmodule : modem_dial_sequencer_tb_top

`default_nettype wire
